/* File: rtl/usb_dev_cfg_regs.sv */
// Device configuration registers: address, mode, hardware configuration.
// Assumes synchronous command/data strobes and one-cycle USB event pulses.
`default_nettype none

module usb_dev_cfg_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cmd_strobe,
    input wire logic [7:0] cmd_code,
    input wire logic wr_strobe,
    input wire logic [15:0] wr_data,
    input wire logic rd_strobe,
    output logic [15:0] rd_data,
    output logic rd_valid,
    input wire logic usb_bus_reset,
    input wire logic status_acked,
    input wire logic ev_bulk_ack,
    input wire logic ev_iso_done,
    input wire logic ev_nak,
    input wire logic ev_error,
    output logic [6:0] usb_address_field,
    output logic device_enable,
    output logic dma_width_select,
    output logic suspend_trigger,
    output logic internal_pullup_enable,
    output logic external_pullup_used,
    output logic irq_out,
    output logic [15:0] hw_config_out
);
    import usb_dev_cfg_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] cmd_r;
    logic [7:0] usb_device_address_r;
    logic [7:0] device_mode_control_r;
    logic [15:0] hardware_configuration_r;
    logic addr_pending_r;
    logic [6:0] act_addr_r;
    logic act_en_r;
    logic [15:0] rd_data_r;
    logic rd_valid_r;
    logic dma_r;
    logic susp_r;
    logic pullup_r;
    logic extpu_r;
    logic irq_r;
    logic [15:0] hwcf_out_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic wr_addr = wr_strobe && cmd_r == CMD_ADDR_WR;
    wire logic wr_mode = wr_strobe && cmd_r == CMD_MODE_WR;
    wire logic wr_hwcf = wr_strobe && cmd_r == CMD_HWCF_WR;
    // Upper byte dropped; reserved bits stored as zero
    wire logic [7:0] mode_wr_val = wr_data[7:0] & MODE_WR_MASK;
    // Bus reset clears only the non-retained bits
    wire logic [7:0] mode_rst_val = device_mode_control_r & MODE_KEEP_MASK;
    wire logic susp_fall = wr_mode && device_mode_control_r[MODE_SUSP_BIT]
        && !mode_wr_val[MODE_SUSP_BIT];
    wire logic [7:0] mode_nxt = wr_mode ? mode_wr_val
        : (usb_bus_reset ? mode_rst_val : device_mode_control_r);
    wire logic [7:0] addr_nxt = wr_addr ? wr_data[7:0] : usb_device_address_r;
    wire logic [15:0] hwcf_nxt = wr_hwcf ? (wr_data & HWCF_WR_MASK)
        : hardware_configuration_r;
    // A write in the acknowledge cycle stays pending: the set wins
    wire logic pending_nxt = wr_addr
        || (addr_pending_r && !status_acked && !usb_bus_reset);
    wire logic take_new = addr_pending_r && status_acked && !usb_bus_reset;
    wire logic [6:0] act_addr_nxt = usb_bus_reset ? BUSRST_ADDR
        : (take_new ? usb_device_address_r[6:0] : act_addr_r);
    wire logic act_en_nxt = usb_bus_reset ? 1'b1
        : (take_new ? usb_device_address_r[ADDR_EN_BIT] : act_en_r);
    wire logic irq_src = device_mode_control_r[MODE_DBG_BIT] ? (ev_nak || ev_error)
        : (ev_bulk_ack || ev_iso_done);
    wire logic irq_nxt = device_mode_control_r[MODE_IRQEN_BIT] && irq_src;
    wire logic pullup_nxt = device_mode_control_r[MODE_PULLUP_BIT]
        && !hardware_configuration_r[HWCF_EXTPU_BIT];
    wire logic [15:0] rd_mux = (cmd_r == CMD_ADDR_RD) ? {8'h00, usb_device_address_r}
        : (cmd_r == CMD_MODE_RD) ? {8'h00, device_mode_control_r}
        : (cmd_r == CMD_HWCF_RD) ? hardware_configuration_r : 16'h0000;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd_r <= CMD_NONE;
            usb_device_address_r <= ADDR_RST;
            device_mode_control_r <= MODE_RST;
            hardware_configuration_r <= HWCF_RST;
            addr_pending_r <= 1'b0;
            act_addr_r <= BUSRST_ADDR;
            act_en_r <= 1'b0;
        end else if (ce) begin
            if (cmd_strobe) begin
                cmd_r <= cmd_code;
            end
            usb_device_address_r <= addr_nxt;
            device_mode_control_r <= mode_nxt;
            hardware_configuration_r <= hwcf_nxt;
            addr_pending_r <= pending_nxt;
            act_addr_r <= act_addr_nxt;
            act_en_r <= act_en_nxt;
        end
    end

    // Outputs registered so every pin comes from a flop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data_r <= 16'h0000;
            rd_valid_r <= 1'b0;
            dma_r <= 1'b0;
            susp_r <= 1'b0;
            pullup_r <= 1'b0;
            extpu_r <= 1'b0;
            irq_r <= 1'b0;
            hwcf_out_r <= HWCF_RST;
        end else if (ce) begin
            rd_valid_r <= rd_strobe;
            if (rd_strobe) begin
                rd_data_r <= rd_mux;
            end
            dma_r <= device_mode_control_r[MODE_DMA_BIT];
            susp_r <= susp_fall;
            pullup_r <= pullup_nxt;
            extpu_r <= hardware_configuration_r[HWCF_EXTPU_BIT];
            irq_r <= irq_nxt;
            hwcf_out_r <= hardware_configuration_r;
        end
    end

    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign usb_address_field = act_addr_r;
    assign device_enable = act_en_r;
    assign dma_width_select = dma_r;
    assign suspend_trigger = susp_r;
    assign internal_pullup_enable = pullup_r;
    assign external_pullup_used = extpu_r;
    assign irq_out = irq_r;
    assign hw_config_out = hwcf_out_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_ADDR_WRITE: assert property (@(posedge mclk) disable iff (rst)
        ce && wr_addr |=> usb_device_address_r == $past(wr_data[7:0]))
        else $error("address write lost");
    AST_BUSRST_ACTIVE: assert property (@(posedge mclk) disable iff (rst)
        ce && usb_bus_reset |=> usb_address_field == 7'h00 && device_enable)
        else $error("bus reset did not force address zero");
    AST_BUSRST_KEEP_ADDR: assert property (@(posedge mclk) disable iff (rst)
        usb_bus_reset && !wr_addr |=> $stable(usb_device_address_r))
        else $error("bus reset altered address register");
    AST_SWITCH_ON_ACK: assert property (@(posedge mclk) disable iff (rst)
        ce && take_new |=> usb_address_field == $past(usb_device_address_r[6:0])
        && device_enable == $past(usb_device_address_r[ADDR_EN_BIT]))
        else $error("new address not taken on acknowledge");
    AST_HOLD_OLD: assert property (@(posedge mclk) disable iff (rst)
        !status_acked && !usb_bus_reset |=> $stable(usb_address_field))
        else $error("active address changed without acknowledge");
    AST_MODE_UPPER: assert property (@(posedge mclk) disable iff (rst)
        ce && wr_mode |=> device_mode_control_r == ($past(wr_data[7:0]) & 8'had))
        else $error("mode write mishandled");
    AST_DMA: assert property (@(posedge mclk) disable iff (rst)
        ce && wr_mode ##1 ce |=> dma_width_select == $past(wr_data[7], 2))
        else $error("dma width not following mode bit");
    AST_SUSPEND: assert property (@(posedge mclk) disable iff (rst)
        $past(ce) && suspend_trigger |-> $past(device_mode_control_r[MODE_SUSP_BIT]) && $past(wr_mode)
        && !device_mode_control_r[MODE_SUSP_BIT])
        else $error("suspend without one-then-zero write");
    AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (rst)
        irq_out |-> $past(device_mode_control_r[3]))
        else $error("interrupt while globally disabled");
    AST_IRQ_DBG: assert property (@(posedge mclk) disable iff (rst)
        ce && device_mode_control_r[3] && device_mode_control_r[2] && ev_nak |=> irq_out)
        else $error("NAK did not interrupt in debug mode");
    AST_PULLUP: assert property (@(posedge mclk) disable iff (rst)
        internal_pullup_enable |-> !$past(hardware_configuration_r[14]))
        else $error("internal pull-up on with external pull-up set");
    AST_MODE_BUSRST: assert property (@(posedge mclk) disable iff (rst)
        ce && usb_bus_reset && !wr_mode |=> device_mode_control_r == ($past(device_mode_control_r) & 8'h8f))
        else $error("bus reset mishandled mode bits");
    AST_HWCF_BUSRST: assert property (@(posedge mclk) disable iff (rst)
        !wr_hwcf |=> $stable(hardware_configuration_r))
        else $error("hardware configuration changed without write");
    AST_RESERVED: assert property (@(posedge mclk) disable iff (rst)
        device_mode_control_r[6] == 1'b0 && device_mode_control_r[4] == 1'b0
        && device_mode_control_r[1] == 1'b0)
        else $error("reserved mode bit set");
    // Checked from the bus side so a broken mask path still shows up
    AST_SUSPEND_FIRES: assert property (@(posedge mclk) disable iff (rst)
        ce && wr_mode && device_mode_control_r[MODE_SUSP_BIT] && !wr_data[MODE_SUSP_BIT] |=> suspend_trigger)
        else $error("one-then-zero write did not suspend");
    AST_HOLD_EN: assert property (@(posedge mclk) disable iff (rst)
        !status_acked && !usb_bus_reset |=> $stable(device_enable))
        else $error("device enable changed without acknowledge");
    AST_RD_ANSWER: assert property (@(posedge mclk) disable iff (rst)
        ce && rd_strobe |=> rd_valid)
        else $error("read not answered");

endmodule // usb_dev_cfg_regs

`default_nettype wire

/* File: rtl/usb_dev_cfg_pkg.sv */
// Constants for the device-side configuration register bank.
// Assumes a command-then-data processor bus with 16-bit data.
`default_nettype none

package usb_dev_cfg_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_ADDR_WR = 8'hb6;
    localparam logic [7:0] CMD_ADDR_RD = 8'hb7;
    localparam logic [7:0] CMD_MODE_WR = 8'hb8;
    localparam logic [7:0] CMD_MODE_RD = 8'hb9;
    localparam logic [7:0] CMD_HWCF_WR = 8'hba;
    localparam logic [7:0] CMD_HWCF_RD = 8'hbb;
    localparam logic [7:0] CMD_NONE = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ADDR_EN_BIT = 7;
    localparam int MODE_DMA_BIT = 7;
    localparam int MODE_SUSP_BIT = 5;
    localparam int MODE_IRQEN_BIT = 3;
    localparam int MODE_DBG_BIT = 2;
    localparam int MODE_PULLUP_BIT = 0;
    localparam int HWCF_EXTPU_BIT = 14;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [15:0] HWCF_RST = 16'h2340;
    localparam logic [7:0] MODE_WR_MASK = 8'had;
    localparam logic [7:0] MODE_KEEP_MASK = 8'h8f;
    localparam logic [15:0] HWCF_WR_MASK = 16'h7fff;
    localparam logic [6:0] BUSRST_ADDR = 7'h00;

endpackage

`default_nettype wire

/* File: verif/cpu_bus_model.sv */
// Processor-side model: command code first, then one data word.
// Assumes one calling process; strobes change 1 ns after mclk rises.
`default_nettype none
module cpu_bus_model (
    input wire logic mclk,
    output logic ce,
    output logic cmd_strobe,
    output logic [7:0] cmd_code,
    output logic wr_strobe,
    output logic [15:0] wr_data,
    output logic rd_strobe,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {ce, cmd_strobe, cmd_code, wr_strobe, wr_data, rd_strobe} = {1'b1, 27'h0};
    end
    // Released lines show the inverse, not a stale copy
    task automatic cmd(input logic [7:0] c);
        @(posedge mclk) #1;
        cmd_strobe = 1'b1;
        cmd_code = c;
        @(posedge mclk) #1;
        cmd_strobe = 1'b0;
        cmd_code = ~c;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        cmd(c);
        wr_strobe = 1'b1;
        wr_data = d;
        @(posedge mclk) #1;
        wr_strobe = 1'b0;
        wr_data = ~d;
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
        cmd(c);
        rd_strobe = 1'b1;
        @(posedge mclk) #1;
        rd_strobe = 1'b0;
        d = rd_data;
        v = rd_valid;
    endtask
    // Clock-enable low for n edges; everything in the block must hold
    task automatic stall(input int n);
        @(posedge mclk) #1;
        ce = 1'b0;
        repeat (n) @(posedge mclk);
        #1;
        ce = 1'b1;
    endtask
endmodule // cpu_bus_model
`default_nettype wire

/* File: verif/tb.sv */
// Bench for the configuration register bank, driven through the cpu model.
// Assumes USB-side events are one-cycle pulses driven by the bench.
`default_nettype none
module tb import usb_dev_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1;
    logic [5:0] u = 6'h00;
    wire ce, cs, ws, rs, rv, den, dws, sus, ipe, epu, irq;
    wire [7:0] cc;
    wire [15:0] wd, rdd, hwc;
    wire [6:0] uaf;
    int fail_count = 0, num_checks = 0, cyc = 0, irq_n = 0, sus_n = 0, n;
    logic [7:0] mv [3] = '{8'h08, 8'h0c, 8'h00};
    always #5 mclk = ~mclk;
    cpu_bus_model host (.mclk(mclk), .ce(ce), .cmd_strobe(cs), .cmd_code(cc), .wr_strobe(ws),
        .wr_data(wd), .rd_strobe(rs), .rd_data(rdd), .rd_valid(rv));
    usb_dev_cfg_regs dut (.mclk(mclk), .rst(rst), .ce(ce), .cmd_strobe(cs), .cmd_code(cc),
        .wr_strobe(ws), .wr_data(wd), .rd_strobe(rs), .rd_data(rdd), .rd_valid(rv),
        .usb_bus_reset(u[5]), .status_acked(u[4]), .ev_bulk_ack(u[0]), .ev_iso_done(u[1]),
        .ev_nak(u[2]), .ev_error(u[3]), .usb_address_field(uaf), .device_enable(den),
        .dma_width_select(dws), .suspend_trigger(sus), .internal_pullup_enable(ipe),
        .external_pullup_used(epu), .irq_out(irq), .hw_config_out(hwc));
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic rdc(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] d;
        logic v;
        host.rd(c, d, v);
        chk(16'(v), 16'h0001);
        chk(d, e);
    endtask
    task automatic pul(input int i);
        @(posedge mclk) #1;
        u[i] = 1'b1;
        @(posedge mclk) #1;
        u[i] = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irq_n <= irq_n + 1;
        if (sus === 1'b1) sus_n <= sus_n + 1;
        if (cyc == 2000) begin
            fail_count++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst = 0;
        rdc(CMD_ADDR_RD, 16'h0000);
        rdc(CMD_MODE_RD, 16'h0000);
        rdc(CMD_HWCF_RD, 16'h2340);
        chk(hwc, 16'h2340);
        chk(16'(epu), 16'h0000);
        host.wr(CMD_ADDR_WR, 16'hff85);
        rdc(CMD_ADDR_RD, 16'h0085);
        chk(16'(uaf), 16'h0000);
        pul(4);
        chk(16'(uaf), 16'h0005);
        chk(16'(den), 16'h0001);
        host.wr(CMD_ADDR_WR, 16'h0003);
        chk(16'(uaf), 16'h0005);
        pul(5);
        chk(16'(uaf), 16'h0000);
        chk(16'(den), 16'h0001);
        rdc(CMD_ADDR_RD, 16'h0003);
        // Reserved bits written as ones on purpose
        host.wr(CMD_MODE_WR, 16'hffff);
        rdc(CMD_MODE_RD, 16'h00ad);
        chk(16'(sus_n), 16'h0000);
        host.wr(CMD_MODE_WR, 16'h008d);
        repeat (3) @(posedge mclk);
        #1;
        chk(16'(sus_n), 16'h0001);
        chk(16'(dws), 16'h0001);
        chk(16'(ipe), 16'h0001);
        host.wr(CMD_MODE_WR, 16'h00ad);
        pul(5);
        rdc(CMD_MODE_RD, 16'h008d);
        host.wr(CMD_HWCF_WR, 16'hffff);
        rdc(CMD_HWCF_RD, 16'h7fff);
        chk(hwc, 16'h7fff);
        chk(16'(epu), 16'h0001);
        chk(16'(ipe), 16'h0000);
        pul(5);
        rdc(CMD_HWCF_RD, 16'h7fff);
        rdc(8'hb5, 16'h0000);
        for (int m = 0; m < 3; m++) begin
            host.wr(CMD_MODE_WR, {8'h00, mv[m]});
            for (int e = 0; e < 4; e++) begin
                n = irq_n;
                pul(e);
                chk(16'(irq_n - n), 16'((m == 0 && e < 2) || (m == 1 && e > 1)));
            end
        end
        // Acknowledge while frozen must be lost; the next one switches
        host.wr(CMD_ADDR_WR, 16'h000a);
        fork
            host.stall(3);
            pul(4);
        join
        chk(16'(uaf), 16'h0000);
        chk(16'(den), 16'h0001);
        pul(4);
        chk(16'(uaf), 16'h000a);
        chk(16'(den), 16'h0000);
        chk(16'(dws), 16'h0000);
        chk(16'(sus_n), 16'h0001);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
